// File: src/spi_host_end.sv
// host end: makes the serial clock by division and runs framed transfers
// assumes the user holds wr_data valid whenever a write may take a byte
`include "spi_port_defines.svh"

module spi_host_end #(
	parameter int unsigned SOFT_RESET_WAIT = `SOFT_RESET_WAIT_CYCLES
) (
	input  wire logic              clock,
	input  wire logic              srst,
	spi_link_if.host               link,
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire logic              cmd_read,
	input  wire spi_port_pkg::reg_addr_t cmd_addr,
	input  wire logic [3:0]        cmd_len,
	input  wire logic              lsb_first,
	input  wire logic              stall_req,
	input  wire spi_port_pkg::byte_t wr_data,
	output logic                   wr_take,
	output spi_port_pkg::byte_t    rd_data,
	output logic                   rd_valid,
	output logic                   busy
);
	import spi_port_pkg::*;

	// ****************************************
	// state and pins
	// ****************************************
	host_state_t  state;
	logic [19:0]  tcnt;
	logic [19:0]  wait_limit;
	logic         sclk;
	logic         sel_n;
	logic         sdo;
	logic         oe;
	logic [3:0]   bit_cnt;
	logic [3:0]   bytes_left;
	logic         in_data;
	logic         is_read;
	logic         first_byte;
	logic         soft_pending;
	logic         stalled;
	logic [15:0]  tx;
	byte_t        rx;
	logic         s_meta;
	logic         s_sync;
	logic         tick;
	logic         unit_last;
	logic         more_bytes;

	function automatic logic [2:0] bit_pos(input logic [2:0] cnt,
		input logic lsb);
		bit_pos = lsb ? cnt : 3'(3'h7 - cnt);
	endfunction : bit_pos

	assign tick       = (state == H_SHIFT)
		&& (tcnt == 20'(`SCLK_HALF_CYCLES - 1));
	assign unit_last  = in_data ? (bit_cnt[2:0] == 3'h7)
		: (bit_cnt == 4'(`INSTR_BITS - 1));
	assign more_bytes = !in_data || (bytes_left > 4'h1);
	assign wr_take    = tick && sclk && unit_last && more_bytes && !is_read;
	assign cmd_ready  = (state == H_IDLE);
	assign busy       = (state != H_IDLE);

	assign link.serial_clock  = sclk;
	assign link.port_select_n = sel_n;
	assign link.host_sdio_out = sdo;
	assign link.host_sdio_oe  = oe;

	always_ff @(posedge clock) begin
		if (srst) begin
			s_meta <= 1'b1;
			s_sync <= 1'b1;
		end else begin
			s_meta <= link.sdio;
			s_sync <= s_meta;
		end
	end

	// ****************************************
	// transfer sequencer
	// ****************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			state        <= H_IDLE;
			tcnt         <= 20'h00000;
			wait_limit   <= 20'h00000;
			sclk         <= 1'b0;
			sel_n        <= 1'b1;
			sdo          <= 1'b0;
			oe           <= 1'b0;
			bit_cnt      <= 4'h0;
			bytes_left   <= 4'h0;
			in_data      <= 1'b0;
			is_read      <= 1'b0;
			first_byte   <= 1'b0;
			soft_pending <= 1'b0;
			stalled      <= 1'b0;
			tx           <= 16'h0000;
			rx           <= 8'h00;
			rd_data      <= 8'h00;
			rd_valid     <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			tcnt     <= tcnt + 20'h00001;
			unique case (state)
				H_IDLE: begin
					tcnt <= 20'h00000;
					if (cmd_valid) begin
						state      <= H_SETUP;
						sel_n      <= 1'b0;
						tx         <= {cmd_read, cmd_addr};
						sdo        <= cmd_read;
						oe         <= 1'b1;
						is_read    <= cmd_read;
						bytes_left <= (cmd_len == 4'h0) ? 4'h1 : cmd_len;
						bit_cnt    <= 4'h0;
						in_data    <= 1'b0;
						first_byte <= !cmd_read && (cmd_addr == `CFG_A_ADDR);
					end
				end
				H_SETUP: begin
					// select settles before the first rising edge
					if (tcnt == 20'(`SELECT_SETUP_CYCLES - 1)) begin
						state <= H_SHIFT;
						tcnt  <= 20'h00000;
						sel_n <= 1'b0;
					end
				end
				H_SHIFT: begin
					if (tick) begin
						tcnt <= 20'h00000;
						sclk <= !sclk;
						if (!sclk && in_data && is_read) begin
							rx[bit_pos(bit_cnt[2:0], lsb_first)] <= s_sync;
						end
						if (sclk && !unit_last) begin
							bit_cnt <= bit_cnt + 4'h1;
							sdo     <= in_data
								? tx[bit_pos(3'(bit_cnt[2:0] + 3'h1), lsb_first)]
								: tx[4'(4'hE - bit_cnt)];
						end else if (sclk && unit_last) begin
							bit_cnt <= 4'h0;
							in_data <= 1'b1;
							if (in_data && is_read) begin
								rd_data  <= rx;
								rd_valid <= 1'b1;
							end
							if (in_data && first_byte &&
								(tx[`SOFT_RST_HI] || tx[`SOFT_RST_LO])) begin
								soft_pending <= 1'b1;
							end
							if (in_data) begin
								first_byte <= 1'b0;
								bytes_left <= bytes_left - 4'h1;
							end
							if (more_bytes) begin
								oe <= !is_read;
								if (!is_read) begin
									tx  <= {8'h00, wr_data};
									sdo <= wr_data[bit_pos(3'h0, lsb_first)];
								end
								if (stall_req && in_data) begin
									state   <= H_WAIT;
									stalled <= 1'b1;
									sel_n   <= 1'b1;
									wait_limit <= 20'(`STALL_CYCLES - 1);
								end
							end else begin
								state   <= H_WAIT;
								stalled <= 1'b0;
								sel_n   <= 1'b1;
								oe      <= 1'b0;
								wait_limit <= 20'(`HOST_GAP_CYCLES - 1);
							end
						end
					end
				end
				H_WAIT: begin
					if (tcnt >= wait_limit) begin
						tcnt <= 20'h00000;
						if (stalled) begin
							state   <= H_SHIFT;
							stalled <= 1'b0;
							sel_n   <= 1'b0;
						end else if (soft_pending) begin
							// quiet period after a soft reset
							soft_pending <= 1'b0;
							wait_limit   <= 20'(SOFT_RESET_WAIT - 1);
						end else begin
							state <= H_IDLE;
						end
					end
				end
			endcase
		end
	end
endmodule : spi_host_end

// File: src/spi_port_defines.svh
// constants of the three-wire register port: addresses, fields, timing
// assumes a 200 MHz system clock on both ends
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

`define INSTR_BITS          16
`define REG_COUNT           16
`define CFG_A_ADDR          15'h0000
`define CFG_A_RESET         8'h00
`define REG_RESET           8'h00
`define SOFT_RESET_VALUE    8'h81
`define SOFT_RST_HI         7
`define SOFT_RST_LO         0
`define LSB_FIRST_HI        6
`define LSB_FIRST_LO        1
`define ASCEND_HI           5
`define ASCEND_LO           2

`define CLOCK_MHZ           200
`define FRAME_GAP_NS        1000
`define FRAME_GAP_CYCLES    ((`FRAME_GAP_NS * `CLOCK_MHZ) / 1000)
`define SCLK_HALF_NS        50
`define SCLK_HALF_CYCLES    ((`SCLK_HALF_NS * `CLOCK_MHZ + 999) / 1000)
`define SELECT_SETUP_NS     20
`define SELECT_SETUP_CYCLES ((`SELECT_SETUP_NS * `CLOCK_MHZ + 999) / 1000)
`define HOST_GAP_NS         1500
`define HOST_GAP_CYCLES     ((`HOST_GAP_NS * `CLOCK_MHZ + 999) / 1000)
`define STALL_NS            400
`define STALL_CYCLES        ((`STALL_NS * `CLOCK_MHZ + 999) / 1000)
`define SOFT_RESET_WAIT_MS  5
`define SOFT_RESET_WAIT_CYCLES (`SOFT_RESET_WAIT_MS * `CLOCK_MHZ * 1000)

`endif

// File: src/spi_port_pkg.sv
// types shared by both ends of the register port
// assumes spi_port_defines.svh for all numbers
package spi_port_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [14:0] reg_addr_t;
	typedef enum logic {
		PH_INSTR = 1'b0,
		PH_DATA  = 1'b1
	} frame_phase_t;
	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_SETUP = 2'b01,
		H_SHIFT = 2'b10,
		H_WAIT  = 2'b11
	} host_state_t;
endpackage : spi_port_pkg

// File: src/spi_link_if.sv
// the three wires between host and register port
// assumes a pull-up on the data wire when neither end drives it
interface spi_link_if;
	logic serial_clock;
	logic port_select_n;
	logic host_sdio_out;
	logic host_sdio_oe;
	logic dev_sdio_out;
	logic dev_sdio_oe;
	logic sdio;

	// resolved level of the shared data wire
	assign sdio = dev_sdio_oe ? dev_sdio_out :
		(host_sdio_oe ? host_sdio_out : 1'b1);

	modport device (
		input  serial_clock,
		input  port_select_n,
		input  sdio,
		output dev_sdio_out,
		output dev_sdio_oe
	);
	modport host (
		output serial_clock,
		output port_select_n,
		output host_sdio_out,
		output host_sdio_oe,
		input  sdio
	);
endinterface : spi_link_if

// File: src/serial_register_port.sv
// device end of the three-wire register port with a byte register file
// assumes the host makes serial_clock and changes data on its falling edge
`include "spi_port_defines.svh"

module serial_register_port (
	input  wire logic   clock,
	input  wire logic   srst,
	spi_link_if.device  link,
	output logic        soft_reset_pulse,
	output logic        alt_function_en,
	output logic        port_active
);
	import spi_port_pkg::*;

	// ****************************************
	// system clock side
	// ****************************************
	localparam logic [8:0] GAP_LIMIT = 9'(`FRAME_GAP_CYCLES);

	logic       sel_meta;
	logic       sel_sync;
	logic [8:0] gap_cnt;
	logic       frame_clear;
	logic       link_reset;
	logic       tgl_meta;
	logic       tgl_sync;
	logic       tgl_last;
	logic       soft_tgl;

	always_ff @(posedge clock) begin
		if (srst) begin
			sel_meta <= 1'b1;
			sel_sync <= 1'b1;
		end else begin
			sel_meta <= link.port_select_n;
			sel_sync <= sel_meta;
		end
	end

	// long select-high ends the frame; short one is a stall
	always_ff @(posedge clock) begin
		if (srst || !sel_sync) begin
			gap_cnt <= 9'h000;
		end else if (gap_cnt != GAP_LIMIT) begin
			gap_cnt <= gap_cnt + 9'h001;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			frame_clear     <= 1'b1;
			link_reset      <= 1'b1;
			alt_function_en <= 1'b0;
			port_active     <= 1'b0;
		end else begin
			frame_clear     <= (gap_cnt == GAP_LIMIT);
			link_reset      <= 1'b0;
			alt_function_en <= (gap_cnt == GAP_LIMIT);
			port_active     <= !sel_sync;
		end
	end

	// soft reset event crosses as a toggle
	always_ff @(posedge clock) begin
		if (srst) begin
			tgl_meta         <= 1'b0;
			tgl_sync         <= 1'b0;
			tgl_last         <= 1'b0;
			soft_reset_pulse <= 1'b0;
		end else begin
			tgl_meta         <= soft_tgl;
			tgl_sync         <= tgl_meta;
			tgl_last         <= tgl_sync;
			soft_reset_pulse <= tgl_sync ^ tgl_last;
		end
	end

	// ****************************************
	// serial clock side
	// ****************************************
	frame_phase_t phase;
	logic [3:0]   bit_cnt;
	logic [14:0]  instr_sh;
	logic         is_read;
	reg_addr_t    addr;
	byte_t        rx;
	byte_t        wbyte;
	byte_t        rd_byte;
	byte_t        regs [`REG_COUNT];
	logic         lsb_first;
	logic         ascend;
	logic         drive;
	logic         out_bit;
	logic         byte_done;

	function automatic logic [2:0] bit_pos(input logic [2:0] cnt,
		input logic lsb);
		bit_pos = lsb ? cnt : 3'(3'h7 - cnt);
	endfunction : bit_pos

	function automatic logic in_map(input reg_addr_t a);
		in_map = (a < 15'(`REG_COUNT));
	endfunction : in_map

	assign lsb_first = regs[0][`LSB_FIRST_HI] | regs[0][`LSB_FIRST_LO];
	assign ascend    = regs[0][`ASCEND_HI] | regs[0][`ASCEND_LO];
	assign byte_done = (phase == PH_DATA) && (bit_cnt[2:0] == 3'h7);

	always_comb begin
		wbyte = rx;
		wbyte[bit_pos(bit_cnt[2:0], lsb_first)] = link.sdio;
	end

	assign rd_byte = in_map(addr) ? regs[addr[3:0]] : 8'h00;

	// frame sequencing on rising serial clock
	always_ff @(posedge link.serial_clock or posedge frame_clear) begin
		if (frame_clear) begin
			phase    <= PH_INSTR;
			bit_cnt  <= 4'h0;
			instr_sh <= 15'h0000;
			is_read  <= 1'b0;
			addr     <= 15'h0000;
			rx       <= 8'h00;
		end else if (!link.port_select_n) begin
			unique case (phase)
				PH_INSTR: begin
					instr_sh <= {instr_sh[13:0], link.sdio};
					bit_cnt  <= bit_cnt + 4'h1;
					if (bit_cnt == 4'(`INSTR_BITS - 1)) begin
						phase   <= PH_DATA;
						bit_cnt <= 4'h0;
						is_read <= instr_sh[14];
						addr    <= {instr_sh[13:0], link.sdio};
					end
				end
				PH_DATA: begin
					rx      <= wbyte;
					bit_cnt <= {1'b0, 3'(bit_cnt[2:0] + 3'h1)};
					if (byte_done) begin
						addr <= ascend ? 15'(addr + 15'h0001)
							: 15'(addr - 15'h0001);
					end
				end
			endcase
		end
	end

	// register file, written at the last bit of each in-map data byte of a write frame
	always_ff @(posedge link.serial_clock or posedge link_reset) begin
		if (link_reset) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				regs[i] <= `REG_RESET;
			end
			regs[0]  <= `CFG_A_RESET;
			soft_tgl <= 1'b0;
		end else if (!link.port_select_n && byte_done && !is_read) begin
			if (addr == `CFG_A_ADDR) begin
				if (wbyte[`SOFT_RST_HI] || wbyte[`SOFT_RST_LO]) begin
					for (int i = 0; i < `REG_COUNT; i++) begin
						regs[i] <= `REG_RESET;
					end
					regs[0]  <= `CFG_A_RESET;
					soft_tgl <= !soft_tgl;
				end else begin
					regs[0] <= wbyte;
				end
			end else if (in_map(addr)) begin
				regs[addr[3:0]] <= wbyte;
			end
		end
	end

	// read data leaves on the falling serial clock
	always_ff @(negedge link.serial_clock or posedge frame_clear) begin
		if (frame_clear) begin
			drive   <= 1'b0;
			out_bit <= 1'b0;
		end else begin
			drive   <= (phase == PH_DATA) && is_read;
			out_bit <= rd_byte[bit_pos(bit_cnt[2:0], lsb_first)];
		end
	end

	assign link.dev_sdio_out = out_bit;
	// select high releases the pin at once, clock or not
	assign link.dev_sdio_oe  = drive && !link.port_select_n;
endmodule : serial_register_port

// File: dv/spi_link_props.sv
// concurrent checks on the three wires between host end and register port
// assumes both ends run from the bench clock and srst given here
`include "spi_port_defines.svh"

module spi_link_props (
	input wire logic clock,
	input wire logic srst,
	input wire logic serial_clock,
	input wire logic port_select_n,
	input wire logic host_sdio_out,
	input wire logic host_sdio_oe,
	input wire logic dev_sdio_out,
	input wire logic dev_sdio_oe,
	input wire logic sdio
);
	localparam int GAP = `FRAME_GAP_CYCLES;
	logic       sclk_q;
	logic       sclk_rise;
	logic [8:0] hi_cnt;
	logic [7:0] rise_cnt;
	logic       rd_frame;

	// ************************************************
	// frame tracking
	// ************************************************
	assign sclk_rise = serial_clock & ~sclk_q & ~port_select_n;
	always_ff @(posedge clock) begin
		sclk_q <= srst ? 1'b0 : serial_clock;
	end
	always_ff @(posedge clock) begin
		if (srst || !port_select_n)
			hi_cnt <= '0;
		else if (hi_cnt != 9'h1ff)
			hi_cnt <= hi_cnt + 9'h001;
	end
	// long select high ends the frame, short one is a stall
	always_ff @(posedge clock) begin
		if (srst || hi_cnt >= GAP)
			rise_cnt <= '0;
		else if (sclk_rise && rise_cnt != 8'hff)
			rise_cnt <= rise_cnt + 8'h01;
	end
	always_ff @(posedge clock) begin
		if (srst)
			rd_frame <= 1'b0;
		else if (sclk_rise && rise_cnt == 8'h00)
			rd_frame <= sdio;
	end

	// ************************************************
	// assertions
	// ************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	chk_oe_select: assert property (dev_sdio_oe |-> !port_select_n)
		else $error("device drives data while deselected");
	chk_no_contention: assert property (!(dev_sdio_oe && host_sdio_oe))
		else $error("both ends drive the data wire");
	chk_select_setup: assert property ($fell(port_select_n) |->
		!serial_clock [*3])
		else $error("serial clock rose too soon after select");
	chk_sclk_idle: assert property (port_select_n |-> !serial_clock)
		else $error("serial clock high while deselected");
	chk_dev_edge: assert property (dev_sdio_oe && $past(dev_sdio_oe)
		&& $changed(dev_sdio_out) |-> $fell(serial_clock))
		else $error("device data changed off a falling edge");
	chk_host_hold: assert property (host_sdio_oe && $past(host_sdio_oe)
		&& $changed(host_sdio_out) |-> !serial_clock)
		else $error("host data changed while serial clock high");
	chk_turn_point: assert property ($rose(dev_sdio_oe) |-> rd_frame
		&& rise_cnt >= 8'd16 && rise_cnt[2:0] == 3'd0)
		else $error("device turned the data wire at a wrong bit");
	chk_write_quiet: assert property (!rd_frame && rise_cnt != 8'd0
		|-> !dev_sdio_oe)
		else $error("device drove data in a write frame");
	chk_byte_bound: assert property ($rose(port_select_n) |->
		rise_cnt >= 8'd16 && rise_cnt[2:0] == 3'd0)
		else $error("select rose inside a byte");
	chk_host_release: assert property (rd_frame && rise_cnt >= 8'd16
		&& !port_select_n && $fell(serial_clock) |-> ##[0:2] !host_sdio_oe)
		else $error("host kept driving during readback");
	chk_pins_quiet: assert property (port_select_n
		&& $past(port_select_n)
		|-> $stable(serial_clock) && $stable(host_sdio_out))
		else $error("link pins toggled while deselected");
endmodule : spi_link_props

// File: dv/tb_top.sv
// self-checking bench: host end and register port joined by the link
// assumes the design sources and spi_port_defines.svh are compiled first
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import spi_port_pkg::*;

	localparam int SR_WAIT = 50;

	logic      clock = 1'b0;
	logic      srst = 1'b1;
	logic      cmd_valid = 1'b0;
	logic      cmd_read = 1'b0;
	logic      lsb_first = 1'b0;
	logic      stall_req = 1'b0;
	reg_addr_t cmd_addr = '0;
	logic [3:0] cmd_len = 4'h0;
	byte_t     wr_data = 8'h00;
	byte_t     rd_data;
	logic      cmd_ready, wr_take, rd_valid, busy;
	logic      soft_reset_pulse, alt_function_en, port_active;
	logic      asc = 1'b0;
	logic      act_seen = 1'b0;
	logic [31:0] mon = '0;
	int        bad_count = 0, cmp_count = 0, cyc = 0, sr_seen = 0, mon_n = 0;
	int        run_len = 0, base_len = 0;
	byte_t     model[16];
	byte_t     wq[$], rq[$];

	spi_link_if link();
	spi_host_end #(.SOFT_RESET_WAIT(SR_WAIT)) spi_host_end_inst (.clock, .srst,
		.link(link.host), .cmd_valid, .cmd_ready, .cmd_read, .cmd_addr,
		.cmd_len, .lsb_first, .stall_req, .wr_data, .wr_take, .rd_data,
		.rd_valid, .busy);
	serial_register_port serial_register_port_inst (.clock, .srst,
		.link(link.device), .soft_reset_pulse, .alt_function_en,
		.port_active);
	spi_link_props spi_link_props_inst (.clock, .srst,
		.serial_clock(link.serial_clock), .port_select_n(link.port_select_n),
		.host_sdio_out(link.host_sdio_out), .host_sdio_oe(link.host_sdio_oe),
		.dev_sdio_out(link.dev_sdio_out), .dev_sdio_oe(link.dev_sdio_oe),
		.sdio(link.sdio));

	always #2.5 clock = ~clock;

	// ************************************************
	// monitors and watchdog
	// ************************************************
	always @(posedge clock) begin
		cyc++;
		if (soft_reset_pulse === 1'b1) sr_seen++;
		if (port_active === 1'b1) act_seen = 1'b1;
		if (cyc == 90000) begin
			bad_count++;
			close_out();
		end
	end
	always @(posedge link.serial_clock) begin
		if (link.port_select_n === 1'b0) begin
			mon = {mon[30:0], link.sdio};
			mon_n++;
		end
	end

	// ************************************************
	// tasks
	// ************************************************
	task check(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : check

	function automatic byte_t rev(input byte_t b);
		for (int i = 0; i < 8; i++) rev[i] = b[7-i];
	endfunction : rev

	task run(input logic rd, input reg_addr_t a, input logic [3:0] n,
		input logic lsb, input logic stl);
		int wi;
		reg_addr_t ai;
		wi = 0;
		rq = {};
		mon_n = 0;
		act_seen = 1'b0;
		@(negedge clock);
		check("cmd ready", 1, cmd_ready);
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_addr = a;
		cmd_len = n;
		lsb_first = lsb;
		stall_req = stl;
		wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
		for (int t = 0; t < 8000; t++) begin
			@(posedge clock);
			run_len = t;
			if (t > 0 && busy === 1'b0) break;
			if (wr_take === 1'b1) wi++;
			if (rd_valid === 1'b1) rq.push_back(rd_data);
			@(negedge clock);
			cmd_valid = 1'b0;
			if (wi < wq.size()) wr_data = wq[wi];
		end
		check("byte count", n, rd ? rq.size() : wi);
		check("port active", 1, act_seen);
		for (int i = 0; i < n; i++) begin
			ai = reg_addr_t'(asc ? a + i : a - i);
			if (rd)
				check("read byte", (ai < 16) ? model[ai[3:0]] : 8'h00, rq[i]);
			else if (ai < 16)
				model[ai[3:0]] = wq[i];
		end
		if (!rd && a == 0) begin
			asc = wq[0][5] || wq[0][2];
			if (wq[0][7] || wq[0][0]) begin
				model = '{default: 8'h00};
				asc = 1'b0;
			end
		end
		wq = {};
	endtask : run

	task wire_chk(input logic rd, input reg_addr_t a, input byte_t d,
		input logic lsb);
		check("wire bits", 24, mon_n);
		check("wire word", {8'h00, rd, a, lsb ? rev(d) : d},
			{8'h00, mon[23:0]});
	endtask : wire_chk

	task close_out();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	// ************************************************
	// sequence
	// ************************************************
	initial begin
		model = '{default: 8'h00};
		repeat (3) @(negedge clock);
		srst = 1'b0;
		repeat (250) @(negedge clock);
		check("alt function", 1, alt_function_en);
		check("port idle", 0, port_active);
		run(1, 15'h0003, 4'd1, 0, 0);
		wire_chk(1, 15'h0003, 8'h00, 0);
		wq = {8'ha1, 8'hb2, 8'hc3};
		run(0, 15'h0005, 4'd3, 0, 1);
		run(1, 15'h0005, 4'd3, 0, 0);
		wq = {8'h5e};
		run(0, 15'h0009, 4'd1, 0, 0);
		wire_chk(0, 15'h0009, 8'h5e, 0);
		wq = {8'h04};
		run(0, 15'h0000, 4'd1, 0, 0);
		wq = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
		run(0, 15'h000d, 4'd5, 0, 1);
		run(1, 15'h000c, 4'd6, 0, 1);
		wq = {8'h22};
		run(0, 15'h0000, 4'd1, 0, 0);
		wq = {8'h1e};
		run(0, 15'h0002, 4'd1, 1, 0);
		wire_chk(0, 15'h0002, 8'h1e, 1);
		run(1, 15'h0002, 4'd1, 1, 0);
		wire_chk(1, 15'h0002, 8'h1e, 1);
		run(1, 15'h0000, 4'd1, 1, 0);
		base_len = run_len;
		sr_seen = 0;
		wq = {8'h81};
		run(0, 15'h0000, 4'd1, 1, 0);
		check("soft reset pulse", 1, sr_seen);
		check("soft reset wait", base_len + SR_WAIT, run_len);
		run(1, 15'h0005, 4'd1, 0, 0);
		wire_chk(1, 15'h0005, 8'h00, 0);
		run(1, 15'h0000, 4'd1, 0, 0);
		close_out();
	end
endmodule : tb_top
